// ==== verilog/dma_link_pkg.sv ====
// constants shared by the four-channel dma link control block
// ----------------------------------------------------------------------------
// Summary of operation
// - destination modulo codes 1010..1111 wrap within 8 KB up to 256 KB
// - auto-disable bit 7 set clears peripheral request enable at byte count zero
// - control bit 6 is reserved, reads zero, writes ignored
// - link condition 00 disables all channel linking
// - link condition 01 links first target per cycle-steal transfer before zero, only the second target at zero
// - link condition 10 links first target after every cycle-steal transfer only
// - link condition 11 links first target once when byte count reaches zero
// - in continuous mode conditions 01 and 10 never link the first target
// - a link event raises a dma request on the selected target channel
// - first link target bits 3..2 pick channel; own number is configuration error unless link condition is 00
// - second link target bits 1..0 pick channel; own number is configuration error unless link condition is 00
// - cycle-steal mode performs exactly one transfer per request
// - peripheral requests count only while peripheral request enable is set
// - configuration error means no transfer and sets the error flag
// ----------------------------------------------------------------------------
package dma_link_pkg;
  localparam int NUM_CH = 4;
  localparam int BC_W = 24;
  // register byte offsets; each channel owns a 16-byte window
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [1:0] OFS_CTRL = 2'h0;
  localparam logic [1:0] OFS_BCNT = 2'h1;
  localparam logic [1:0] OFS_DADDR = 2'h2;
  localparam logic [1:0] OFS_STAT = 2'h3;
  localparam logic [7:0] ADDR_ISTS = 8'h40;
  localparam logic [7:0] ADDR_IMASK = 8'h44;
  // channel_control field positions
  localparam int SECOND_LINK_TARGET_LSB = 0;
  localparam int FIRST_LINK_TARGET_LSB = 2;
  localparam int LINK_CONDITION_LSB = 4;
  localparam int RSVD_BIT = 6;
  localparam int DREQ_BIT = 7;
  localparam int DESTINATION_MODULO_LSB = 8;
  localparam int START_BIT = 16;
  localparam int CS_BIT = 29;
  localparam int ERQ_BIT = 30;
  // channel_status_reg bits
  localparam int STS_DONE = 0;
  localparam int STS_CE = 1;
  localparam int STS_PEND = 2;
  // link condition codes
  localparam logic [1:0] LINK_NONE = 2'h0;
  localparam logic [1:0] LINK_BOTH = 2'h1;
  localparam logic [1:0] LINK_EACH = 2'h2;
  localparam logic [1:0] LINK_END = 2'h3;
  // destination modulo: lowest supported code and its buffer size
  localparam logic [3:0] DESTINATION_MODULO_FIRST = 4'hA;
  localparam logic [31:0] DESTINATION_MODULO_FIRST_SIZE = 32'h0000_2000;
  // each transfer moves one word
  localparam logic [31:0] XFER_BYTES = 32'h0000_0004;
  localparam logic [BC_W-1:0] XFER_BC = 24'h00_0004;
  // reset values and response codes
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] IMASK_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== verilog/dma_link_decide.sv ====
// per-channel link event decision and self-link configuration check
`timescale 1ns/100ps
module dma_link_decide
(
  input wire logic [1:0] own_id,
  input wire logic [1:0] link_cond,
  input wire logic [1:0] first_target,
  input wire logic [1:0] second_target,
  input wire logic cycle_steal,
  input wire logic xfer_done,
  input wire logic count_zero,
  output logic [3:0] link_req,
  output logic cfg_err
);
  // ----------------------------------------------------------------------
  // link decision
  // ----------------------------------------------------------------------
  // a linked target may equal the own channel only as a configuration error
  always_comb
  begin
    link_req = 4'h0;
    cfg_err = (link_cond != dma_link_pkg::LINK_NONE) &&
              ((first_target == own_id) || (second_target == own_id));
    if (xfer_done)
    begin
      case (link_cond)
        dma_link_pkg::LINK_BOTH:
        begin
          if (count_zero)
            link_req[second_target] = 1'b1;
          else if (cycle_steal)
            link_req[first_target] = 1'b1;
        end
        dma_link_pkg::LINK_EACH:
        begin
          if (cycle_steal)
            link_req[first_target] = 1'b1;
        end
        dma_link_pkg::LINK_END:
        begin
          if (count_zero)
            link_req[first_target] = 1'b1;
        end
        default:
          link_req = 4'h0;
      endcase
    end
  end
endmodule

// ==== verilog/dma_dest_wrap.sv ====
// next destination address with circular-buffer wrap
`timescale 1ns/100ps
module dma_dest_wrap
(
  input wire logic [31:0] addr,
  input wire logic [3:0] modulo,
  output logic [31:0] next_addr
);
  logic [31:0] sum;
  logic [31:0] win;
  // ----------------------------------------------------------------------
  // wrap
  // ----------------------------------------------------------------------
  // codes below the first large size leave the address unwrapped here
  always_comb
  begin
    sum = addr + dma_link_pkg::XFER_BYTES;
    win = (dma_link_pkg::DESTINATION_MODULO_FIRST_SIZE << (modulo - dma_link_pkg::DESTINATION_MODULO_FIRST)) - 32'h1;
    if (modulo >= dma_link_pkg::DESTINATION_MODULO_FIRST)
      next_addr = (addr & ~win) | (sum & win);
    else
      next_addr = sum;
  end
endmodule

// ==== verilog/dma_link_ctrl.sv ====
// four-channel dma link control with axi4-lite registers
`timescale 1ns/100ps
module dma_link_ctrl
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [3:0] PERIPH_REQ,
  output logic [3:0] XFER_STROBE,
  output logic IRQ,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  typedef struct packed {
    logic [3:0][31:0] ctrl;
    logic [3:0][23:0] bcnt;
    logic [3:0][31:0] daddr;
    logic [3:0] pend;
    logic [7:0] ists;
    logic [7:0] imask;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic irq;
    logic [3:0] xfer;
  } state_s;

  state_s q;
  state_s d;
  logic [3:0][3:0] link_vec;
  logic [3:0] cfg_err;
  logic [3:0] grant;
  logic [3:0] cnt_zero;
  logic [3:0][23:0] bc_next;
  logic [3:0][31:0] da_next;

  // ----------------------------------------------------------------------
  // per-channel helpers
  // ----------------------------------------------------------------------
  // the count saturates at zero so a short tail still ends the block
  genvar gi;
  generate
    for (gi = 0; gi < dma_link_pkg::NUM_CH; gi++)
    begin : g_ch
      assign bc_next[gi] = (q.bcnt[gi] > dma_link_pkg::XFER_BC) ?
                           q.bcnt[gi] - dma_link_pkg::XFER_BC : 24'h00_0000;
      assign cnt_zero[gi] = (bc_next[gi] == 24'h00_0000);
      dma_link_decide u_link
      (
        .own_id(2'(gi)),
        .link_cond(q.ctrl[gi][dma_link_pkg::LINK_CONDITION_LSB +: 2]),
        .first_target(q.ctrl[gi][dma_link_pkg::FIRST_LINK_TARGET_LSB +: 2]),
        .second_target(q.ctrl[gi][dma_link_pkg::SECOND_LINK_TARGET_LSB +: 2]),
        .cycle_steal(q.ctrl[gi][dma_link_pkg::CS_BIT]),
        .xfer_done(grant[gi]),
        .count_zero(cnt_zero[gi]),
        .link_req(link_vec[gi]),
        .cfg_err(cfg_err[gi])
      );
      dma_dest_wrap u_wrap
      (
        .addr(q.daddr[gi]),
        .modulo(q.ctrl[gi][dma_link_pkg::DESTINATION_MODULO_LSB +: 4]),
        .next_addr(da_next[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------------
  // fixed priority, channel 0 first; one transfer per cycle across channels
  always_comb
  begin
    grant = 4'h0;
    for (int i = dma_link_pkg::NUM_CH - 1; i >= 0; i--)
    begin
      if (q.pend[i] && !cfg_err[i] && (q.bcnt[i] != 24'h00_0000))
        grant = 4'h1 << i;
    end
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [7:0] ch_base;
    logic [1:0] ch;
    logic [1:0] ofs;
    logic wr_ok;
    logic [31:0] wmask;
    logic [3:0] sw_start;
    logic [3:0] link_in;
    logic [7:0] ev;
    d = q;
    ch_base = 8'h00;
    ch = 2'h0;
    ofs = 2'h0;
    wr_ok = 1'b0;
    wmask = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
    sw_start = 4'h0;
    link_in = 4'h0;
    ev = 8'h00;

    // write channels: each address and data word is taken on its own
    if (S_AXI_AWVALID && q.awready)
    begin
      d.aw_have = 1'b1;
      d.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && q.wready)
    begin
      d.w_have = 1'b1;
      d.wdata = S_AXI_WDATA;
      d.wstrb = S_AXI_WSTRB;
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;
    if (S_AXI_BVALID && S_AXI_BREADY)
    begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end

    // transfer effects of the granted channel
    for (int i = 0; i < dma_link_pkg::NUM_CH; i++)
    begin
      if (grant[i])
      begin
        d.bcnt[i] = bc_next[i];
        d.daddr[i] = da_next[i];
        if (q.ctrl[i][dma_link_pkg::CS_BIT] || cnt_zero[i])
          d.pend[i] = 1'b0;
        if (cnt_zero[i])
        begin
          ev[i] = 1'b1;
          if (q.ctrl[i][dma_link_pkg::DREQ_BIT])
            d.ctrl[i][dma_link_pkg::ERQ_BIT] = 1'b0;
        end
      end
      // a request on a misconfigured channel is dropped and flagged
      if (q.pend[i] && cfg_err[i])
      begin
        d.pend[i] = 1'b0;
        ev[4 + i] = 1'b1;
      end
      else if (q.pend[i] && (q.bcnt[i] == 24'h00_0000))
        d.pend[i] = 1'b0;
      for (int j = 0; j < dma_link_pkg::NUM_CH; j++)
        link_in[i] = link_in[i] | link_vec[j][i];
    end

    // register write, performed once both halves are held
    if (q.aw_have && q.w_have && !q.bvalid)
    begin
      ch = q.awaddr[5:4];
      ofs = q.awaddr[3:2];
      ch_base = q.awaddr;
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.awready = 1'b0;
      d.wready = 1'b0;
      wr_ok = (ch_base < dma_link_pkg::ADDR_ISTS) || (ch_base == dma_link_pkg::ADDR_ISTS) ||
              (ch_base == dma_link_pkg::ADDR_IMASK);
      d.bresp = wr_ok ? dma_link_pkg::RESP_OKAY : dma_link_pkg::RESP_SLVERR;
      if (ch_base < dma_link_pkg::ADDR_ISTS)
      begin
        case (ofs)
          dma_link_pkg::OFS_CTRL:
          begin
            d.ctrl[ch] = (d.ctrl[ch] & ~wmask) | (q.wdata & wmask);
            d.ctrl[ch][dma_link_pkg::RSVD_BIT] = 1'b0;
            d.ctrl[ch][dma_link_pkg::START_BIT] = 1'b0;
            sw_start[ch] = q.wdata[dma_link_pkg::START_BIT] && q.wstrb[2];
          end
          dma_link_pkg::OFS_BCNT:
            d.bcnt[ch] = (d.bcnt[ch] & wmask[23:0]) ^ (d.bcnt[ch] & wmask[23:0]) |
                         (d.bcnt[ch] & ~wmask[23:0]) | (q.wdata[23:0] & wmask[23:0]);
          dma_link_pkg::OFS_DADDR:
            d.daddr[ch] = (d.daddr[ch] & ~wmask) | (q.wdata & wmask);
          default:
            d.bresp = dma_link_pkg::RESP_OKAY;
        endcase
      end
      else if (ch_base == dma_link_pkg::ADDR_ISTS)
        d.ists = q.ists & ~(q.wdata[7:0] & wmask[7:0]);
      else if (ch_base == dma_link_pkg::ADDR_IMASK)
        d.imask = (q.imask & ~wmask[7:0]) | (q.wdata[7:0] & wmask[7:0]);
    end

    // request sources; setting wins over the clears above
    for (int i = 0; i < dma_link_pkg::NUM_CH; i++)
    begin
      if (PERIPH_REQ[i] && q.ctrl[i][dma_link_pkg::ERQ_BIT])
        d.pend[i] = 1'b1;
      if (sw_start[i] || link_in[i])
        d.pend[i] = 1'b1;
    end
    d.ists = d.ists | ev;

    // read channel: one cycle from address to data
    if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end
    if (S_AXI_ARVALID && q.arready)
    begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = dma_link_pkg::RESP_OKAY;
      d.rdata = 32'h0000_0000;
      if (S_AXI_ARADDR < dma_link_pkg::ADDR_ISTS)
      begin
        case (S_AXI_ARADDR[3:2])
          dma_link_pkg::OFS_CTRL:
            d.rdata = q.ctrl[S_AXI_ARADDR[5:4]];
          dma_link_pkg::OFS_BCNT:
            d.rdata = {8'h00, q.bcnt[S_AXI_ARADDR[5:4]]};
          dma_link_pkg::OFS_DADDR:
            d.rdata = q.daddr[S_AXI_ARADDR[5:4]];
          default:
          begin
            d.rdata[dma_link_pkg::STS_DONE] = q.ists[S_AXI_ARADDR[5:4]];
            d.rdata[dma_link_pkg::STS_CE] = q.ists[4 + S_AXI_ARADDR[5:4]];
            d.rdata[dma_link_pkg::STS_PEND] = q.pend[S_AXI_ARADDR[5:4]];
          end
        endcase
      end
      else if (S_AXI_ARADDR == dma_link_pkg::ADDR_ISTS)
        d.rdata = {24'h00_0000, q.ists};
      else if (S_AXI_ARADDR == dma_link_pkg::ADDR_IMASK)
        d.rdata = {24'h00_0000, q.imask};
      else
        d.rresp = dma_link_pkg::RESP_SLVERR;
    end

    d.xfer = grant;
    d.irq = |(d.ists & d.imask);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      q <= '0;
      q.ctrl <= {4{dma_link_pkg::CTRL_RST}};
      q.imask <= dma_link_pkg::IMASK_RST;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end
    else
      q <= d;
  end

  assign XFER_STROBE = q.xfer;
  assign IRQ = q.irq;
  assign S_AXI_AWREADY = q.awready;
  assign S_AXI_WREADY = q.wready;
  assign S_AXI_BRESP = q.bresp;
  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_ARREADY = q.arready;
  assign S_AXI_RDATA = q.rdata;
  assign S_AXI_RRESP = q.rresp;
  assign S_AXI_RVALID = q.rvalid;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  // link requests that reach channel t from any source; the vector is passed in so that
  // the assertions see its sampled value and not the value after the edge
  function automatic logic link_in_any(input logic [3:0][3:0] v, input int t);
    link_in_any = v[0][t] | v[1][t] | v[2][t] | v[3][t];
  endfunction

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  AST_WRAP_TOP: assert property (grant[3] && q.ctrl[3][11:8] == 4'hF &&
    !(q.aw_have && q.w_have && !q.bvalid) |=>
    q.daddr[3][31:18] == $past(q.daddr[3][31:18])) else $error("modulo wrap broke");
  AST_DREQ_CLEAR: assert property (grant[3] && cnt_zero[3] && q.ctrl[3][7] &&
    !(q.aw_have && q.w_have && !q.bvalid) |=> !q.ctrl[3][30])
    else $error("request enable not cleared");
  AST_RSVD_ZERO: assert property (q.ctrl[0][6] == 1'b0 && q.ctrl[1][6] == 1'b0 &&
    q.ctrl[2][6] == 1'b0 && q.ctrl[3][6] == 1'b0) else $error("reserved control bit set");
  AST_NO_LINK: assert property (q.ctrl[0][5:4] == 2'h0 |-> link_vec[0] == 4'h0)
    else $error("link with linking off");
  AST_CONT_LINK: assert property (!q.ctrl[0][29] && q.ctrl[0][5:4] == 2'h2 |->
    link_vec[0] == 4'h0) else $error("continuous mode linked");
  AST_CONT_BOTH: assert property (!q.ctrl[0][29] && q.ctrl[0][5:4] == 2'h1 &&
    !cnt_zero[0] |-> link_vec[0] == 4'h0) else $error("continuous mode linked early");
  AST_EACH_FIRST: assert property (grant[0] && q.ctrl[0][29] && q.ctrl[0][5:4] == 2'h2 |->
    link_vec[0] == (4'h1 << q.ctrl[0][3:2])) else $error("first target not linked");
  AST_END_FIRST: assert property (grant[0] && cnt_zero[0] && q.ctrl[0][5:4] == 2'h3 |->
    link_vec[0] == (4'h1 << q.ctrl[0][3:2])) else $error("end link missing");
  AST_SECOND: assert property (grant[0] && cnt_zero[0] && q.ctrl[0][5:4] == 2'h1 |->
    link_vec[0][q.ctrl[0][1:0]]) else $error("second target not linked");
  AST_LINK_REQ: assert property (link_vec[0][1] |=> q.pend[1] || q.ists[5])
    else $error("linked channel not requested");
  AST_SELF_ERR: assert property (q.pend[2] && cfg_err[2] |-> !grant[2] ##1 q.ists[6])
    else $error("self link not flagged");
  AST_ONE_GRANT: assert property ($onehot0(grant) && $onehot0(XFER_STROBE))
    else $error("two transfers at once");
  AST_CS_ONCE: assert property (grant[0] && q.ctrl[0][29] && !PERIPH_REQ[0] &&
    !link_in_any(link_vec, 0) && !(q.aw_have && q.w_have) |=> !q.pend[0])
    else $error("extra transfer");
  AST_ERQ_GATE: assert property (!q.pend[3] && !q.ctrl[3][30] && PERIPH_REQ[3] &&
    !(q.aw_have && q.w_have) && link_in_any(link_vec, 3) == 1'b0 |=> !q.pend[3])
    else $error("ignored request taken");
  AST_IRQ: assert property (|(q.ists & q.imask) |-> IRQ) else $error("interrupt missing");

  // main scenarios: linked cycle-steal, end-of-block link, self-link, interrupt, wrap
  COV_CS_LINK: cover property (grant[0] && q.ctrl[0][29] && link_vec[0] != 4'h0);
  COV_END_LINK: cover property (grant[0] && cnt_zero[0] && link_vec[0] != 4'h0);
  COV_CFG_ERR: cover property (q.pend[0] && cfg_err[0]);
  COV_IRQ: cover property ($rose(IRQ));
  COV_WRAP: cover property (grant[3] && q.ctrl[3][11:8] >= 4'hA);
endmodule

// ==== verification/periph_model.sv ====
// peripheral request source standing in front of the dma link control block
`timescale 1ns/100ps
module periph_model
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] go,
  input wire logic [3:0] lag,
  output logic [3:0] req
);
  int cnt [4];

  // ----------------------------------------------------------------------
  // request pulses
  // ----------------------------------------------------------------------
  // one-cycle request per go, after lag+1 idle cycles; a held level would be
  // seen again after service, as there is no acknowledge back to us
  always @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      req[i] <= reset_n && !go[i] && (cnt[i] == 1);
      if (!reset_n)
        cnt[i] <= 0;
      else if (go[i])
        cnt[i] <= int'(lag) + 1;
      else if (cnt[i] > 0)
        cnt[i] <= cnt[i] - 1;
    end
  end
endmodule

// ==== verification/dma_channel_link_control_test.sv ====
// self-checking bench for the dma link control block
`timescale 1ns/100ps
module dma_channel_link_control_test;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [3:0] go = 4'h0;
  logic [3:0] lag = 4'h0;
  logic [3:0] preq;
  logic [3:0] strobe;
  logic irq;
  logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
  logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
  logic [31:0] w_data = 32'h0, rdata, rd;
  logic awr, wr, arr, bv, rv;
  logic [1:0] bresp, rresp, resp;
  int num_errors = 0;
  int samples_checked = 0;
  int strobes [4] = '{0, 0, 0, 0};

  always #25 CLK = ~CLK;

  dma_link_ctrl dma_link_ctrl_inst (.CLK(CLK), .RESET_N(RESET_N), .PERIPH_REQ(preq),
    .XFER_STROBE(strobe), .IRQ(irq), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_valid),
    .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(b_ready),
    .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(r_ready));

  periph_model periph_model_inst (.clk(CLK), .reset_n(RESET_N), .go(go), .lag(lag),
    .req(preq));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // transfer counter per channel, sampled on the edge like the design does
  always @(posedge CLK)
    for (int i = 0; i < 4; i++)
      if (RESET_N && strobe[i] === 1'b1)
        strobes[i]++;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
  endtask

  // both write halves offered together, each dropped once taken; bready simply stays
  // high, so back-to-back calls never lower and raise it in one time step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    do
    begin
      @(posedge CLK);
      n++;
      if (aw_valid && awr)
        aw_valid <= 1'b0;
      if (w_valid && wr)
        w_valid <= 1'b0;
    end
    while (bv !== 1'b1 && n < 200);
    resp = bresp;
    if (n >= 200)
      check("write answer", 32'h0, 32'h1);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    int n = 0;
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    do
    begin
      @(posedge CLK);
      n++;
      if (ar_valid && arr)
        ar_valid <= 1'b0;
    end
    while (rv !== 1'b1 && n < 200);
    rd = rdata;
    resp = rresp;
    if (n >= 200)
      check("read answer", 32'h0, 32'h1);
  endtask

  // ch0 links to ch1 (first) and ch2 (second) and moves two words
  task automatic link_case(input int cs, input int c);
    int b0, b1, b2, e1, e2;
    wr_reg(8'h14, 32'h0000_0100);
    wr_reg(8'h24, 32'h0000_0100);
    wr_reg(8'h04, 32'h0000_0008);
    b0 = strobes[0];
    b1 = strobes[1];
    b2 = strobes[2];
    e1 = cs ? ((c == 2) ? 2 : int'(c != 0)) : int'(c == 3);
    e2 = int'(c == 1);
    repeat (cs ? 2 : 1)
    begin
      wr_reg(8'h00, (cs ? 32'h2001_0006 : 32'h0001_0006) | (32'(c) << 4));
      idle(8);
    end
    check("source words", 32'(strobes[0] - b0), 32'h2);
    check("first target", 32'(strobes[1] - b1), 32'(e1));
    check("second target", 32'(strobes[2] - b2), 32'(e2));
    rd_reg(8'h14);
    check("first target count", rd, 32'h0000_0100 - 32'(4 * e1));
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    int cnt, sz;
    logic [31:0] a;
    void'($urandom(32'hAD2B));
    idle(6);
    RESET_N <= 1'b1;
    idle(1);
    rd_reg(8'h00);
    check("ctrl reset", rd, dma_link_pkg::CTRL_RST);
    rd_reg(dma_link_pkg::ADDR_IMASK);
    check("mask reset", rd, 32'h0);
    rd_reg(8'h80);
    check("hole read", 32'(resp), 32'(dma_link_pkg::RESP_SLVERR));
    wr_reg(8'h84, 32'hFFFF_FFFF);
    check("hole write", 32'(resp), 32'(dma_link_pkg::RESP_SLVERR));
    // reserved bit and self-clearing start read back as zero
    wr_reg(8'h20, 32'h2001_0045);
    rd_reg(8'h20);
    check("reserved bit", rd, 32'h2000_0005);
    wr_reg(8'h10, 32'h2000_0000);
    wr_reg(8'h20, 32'h2000_0000);
    for (int cs = 1; cs >= 0; cs--)
      for (int c = 0; c < 4; c++)
        link_case(cs, c);
    // peripheral requests: auto-disable, enable kept, enable off
    for (int k = 0; k < 3; k++)
    begin
      wr_reg(8'h34, 32'h0000_0008);
      wr_reg(8'h30, (k == 0) ? 32'h6000_0080 : (k == 1) ? 32'h6000_0000 : 32'h2000_0000);
      cnt = strobes[3];
      repeat (3)
      begin
        lag <= 4'($urandom_range(0, 3));
        go <= 4'h8;
        idle(1);
        go <= 4'h0;
        idle(10);
      end
      check("peripheral words", 32'(strobes[3] - cnt), (k < 2) ? 32'h2 : 32'h0);
      rd_reg(8'h30);
      check("request enable", 32'(rd[30]), 32'(k == 1));
    end
    // destination wrap for every large buffer code
    for (int code = 10; code < 16; code++)
    begin
      sz = 32'h0000_2000 << (code - 10);
      a = ($urandom & ~32'(sz - 1)) | 32'(sz - 4);
      wr_reg(8'h38, a);
      wr_reg(8'h34, 32'h0000_0004);
      wr_reg(8'h30, 32'h2001_0000 | (32'(code) << 8));
      idle(6);
      rd_reg(8'h38);
      check("wrapped address", rd, a & ~32'(sz - 1));
    end
    // self links: two errors, and a harmless one with linking off
    for (int ch = 1; ch < 4; ch++)
    begin
      wr_reg(8'(ch * 16 + 4), 32'h0000_0004);
      cnt = strobes[ch];
      wr_reg(8'(ch * 16), (ch == 1) ? 32'h2001_0034 : (ch == 2) ? 32'h2001_0022 : 32'h2001_000F);
      idle(6);
      check("error blocks words", 32'(strobes[ch] - cnt), 32'(ch == 3));
      rd_reg(8'(ch * 16 + 12));
      check("error flag", 32'(rd[1]), 32'(ch != 3));
    end
    // interrupt: sticky status, mask, write one to clear
    rd_reg(dma_link_pkg::ADDR_ISTS);
    check("event status", rd, 32'h0000_0069);
    check("irq masked", 32'(irq), 32'h0);
    wr_reg(dma_link_pkg::ADDR_IMASK, 32'h0000_0020);
    idle(2);
    check("irq raised", 32'(irq), 32'h1);
    wr_reg(dma_link_pkg::ADDR_ISTS, 32'h0000_00FF);
    idle(2);
    check("irq cleared", 32'(irq), 32'h0);
    rd_reg(dma_link_pkg::ADDR_ISTS);
    check("status cleared", rd, 32'h0);
    test_done();
  end

  // a hang ends the run through the same closing task
  initial
  begin
    #(50 * 20000);
    num_errors++;
    test_done();
  end
endmodule
